// ---- odp_diag_page.sv ----
`timescale 1ns/10ps
`include "odp_defs.svh"

// How it works
// RQ1: Page answers only at the second device address, A2h, not the identification one.
// RQ2: Temperature stored as signed 16-bit value, 1/256 degree per count.
// RQ3: Supply stored as unsigned 16-bit value, 100 microvolts per count.
// RQ4: Laser bias stored as unsigned 16-bit value, 2 microamps per count.
// RQ5: Transmit power stored as unsigned 16-bit value, 0.1 microwatt per count.
// RQ6: Receive power stored as unsigned 16-bit value, 0.1 microwatt per count.
// RQ7: Calibration bytes 56 to 94 read fixed default values.
// RQ8: Byte 95 holds checksum of bytes 0 to 94, read-only to the host.
// RQ9: Status bit 7 reads the live transmit-off pin level.
// RQ10: Status bit 6 is a host soft transmit-off bit that keeps its value.
// RQ11: Transmitter is disabled when soft bit or transmit-off pin is set.
// RQ12: Status bit 2 reads the transmit-fault output level.
// RQ13: Status bit 1 reads the receive-signal-lost output level.
// RQ14: Status bit 0 reads 1 until measurements are valid, then 0.
// RQ15: Soft commands reach the outputs within 100 ms.
// RQ16: Byte 112 holds high/low alarm flags for temperature, supply, bias, transmit power.
// RQ17: Byte 113 bits 7 and 6 hold receive power alarms; rest reserved.
// RQ18: Byte 116 mirrors byte 112 against warning thresholds.
// RQ19: Byte 117 bits 7 and 6 hold receive power warnings; rest reserved.
// RQ20: Measurements sit MSB first at bytes 96, 98, 100, 102, 104.
// RQ21: Thresholds sit MSB first at bytes 0 to 39, high then low.
// RQ22: Flags recompute on each measurement update; host writes to them are ignored.
// RQ23: Status bits 3 to 5 read zero and ignore writes.
module odp_diag_page #(
  parameter int SOFT_RESP_CYC = `ODP_SOFT_RESP_MS * `ODP_NS_PER_MS / `ODP_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [6:0] dev_sel_addr,
  input wire logic [7:0] byte_addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic prog_en,
  input wire logic meas_valid,
  input wire logic [15:0] meas_temp,
  input wire logic [15:0] meas_vcc,
  input wire logic [15:0] meas_bias,
  input wire logic [15:0] meas_txpwr,
  input wire logic [15:0] meas_rxpwr,
  input wire logic tx_off_pin,
  input wire logic tx_fault_in,
  input wire logic receive_signal_lost_pin_in,
  output logic [7:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic tx_disable_out_ff,
  output logic tx_fault_pin_ff,
  output logic receive_signal_lost_pin_ff
);

  odp_pkg::odp_byte_type thr_ff [`ODP_THR_BYTES];
  odp_pkg::odp_byte_type nxt_thr [`ODP_THR_BYTES];
  odp_pkg::odp_word_type meas_ff [`ODP_N_MEAS];
  odp_pkg::odp_word_type nxt_meas [`ODP_N_MEAS];
  odp_pkg::odp_byte_type alm_ff, nxt_alm, alm_rx_ff, nxt_alm_rx;
  odp_pkg::odp_byte_type wrn_ff, nxt_wrn, wrn_rx_ff, nxt_wrn_rx;
  odp_pkg::odp_byte_type cksum_ff, nxt_cksum, nxt_rd_data, status_byte;
  logic soft_off_ff, nxt_soft_off, not_ready_ff, nxt_not_ready;
  logic off_meta_ff, off_sync_ff;
  logic nxt_rd_valid, nxt_tx_disable, dev_hit;
  logic [`ODP_RESP_CNT_W-1:0] resp_cnt_ff, nxt_resp_cnt;

  // Only the diagnostic device address selects this page.
  assign dev_hit = (dev_sel_addr == `ODP_DIAG_DEV_ADDR); // see RQ1

  // Assembles the status/control byte; reserved bits stay zero.
  always_comb begin
    status_byte = `ODP_ZERO_BYTE; // see RQ23
    status_byte[`ODP_ST_TXOFF_BIT] = off_sync_ff; // see RQ9
    status_byte[`ODP_ST_SOFT_BIT] = soft_off_ff; // see RQ10
    status_byte[`ODP_ST_FAULT_BIT] = tx_fault_pin_ff; // see RQ12
    status_byte[`ODP_ST_LOS_BIT] = receive_signal_lost_pin_ff; // see RQ13
    status_byte[`ODP_ST_NRDY_BIT] = not_ready_ff; // see RQ14
  end

  // Greater-than compare, signed for temperature and unsigned otherwise.
  function automatic logic odp_gt(input logic [15:0] a, input logic [15:0] b,
                                  input logic is_signed);
    odp_gt = is_signed ? ($signed(a) > $signed(b)) : (a > b);
  endfunction

  // Computes the next stored state: thresholds, measurements, flags, soft bit.
  always_comb begin
    logic [15:0] hi_a, lo_a, hi_w, lo_w;
    logic sg;
    int bh;
    hi_a = `ODP_ZERO_WORD;
    lo_a = `ODP_ZERO_WORD;
    hi_w = `ODP_ZERO_WORD;
    lo_w = `ODP_ZERO_WORD;
    sg = 1'b0;
    bh = 0;
    nxt_thr = thr_ff;
    nxt_meas = meas_ff;
    nxt_alm = alm_ff;
    nxt_alm_rx = alm_rx_ff;
    nxt_wrn = wrn_ff;
    nxt_wrn_rx = wrn_rx_ff;
    nxt_soft_off = soft_off_ff;
    nxt_not_ready = not_ready_ff;
    // Thresholds are factory-programmed only, while prog_en is high.
    if (wr_en && dev_hit && prog_en && byte_addr <= `ODP_THR_LAST) begin
      nxt_thr[byte_addr[5:0]] = wr_data; // see RQ21
    end
    // Only the soft bit of the status byte is host-writable.
    if (wr_en && dev_hit && byte_addr == `ODP_STAT_ADDR) begin
      nxt_soft_off = wr_data[`ODP_ST_SOFT_BIT]; // see RQ10
    end
    if (meas_valid) begin // see RQ22
      nxt_meas[0] = meas_temp; // see RQ2
      nxt_meas[1] = meas_vcc; // see RQ3
      nxt_meas[2] = meas_bias; // see RQ4
      nxt_meas[3] = meas_txpwr; // see RQ5
      nxt_meas[4] = meas_rxpwr; // see RQ6
      nxt_not_ready = 1'b0; // see RQ14
      nxt_alm_rx = `ODP_ZERO_BYTE; // see RQ17
      nxt_wrn_rx = `ODP_ZERO_BYTE; // see RQ19
      for (int q = 0; q < `ODP_N_MEAS; q++) begin
        hi_a = {thr_ff[q*`ODP_THR_STRIDE], thr_ff[q*`ODP_THR_STRIDE+1]};
        lo_a = {thr_ff[q*`ODP_THR_STRIDE+`ODP_THR_LWA], thr_ff[q*`ODP_THR_STRIDE+`ODP_THR_LWA+1]};
        hi_w = {thr_ff[q*`ODP_THR_STRIDE+`ODP_THR_HWR], thr_ff[q*`ODP_THR_STRIDE+`ODP_THR_HWR+1]};
        lo_w = {thr_ff[q*`ODP_THR_STRIDE+`ODP_THR_LWR], thr_ff[q*`ODP_THR_STRIDE+`ODP_THR_LWR+1]};
        sg = (q == 0);
        if (q == `ODP_RX_MEAS) begin
          nxt_alm_rx[7] = odp_gt(nxt_meas[q], hi_a, sg); // see RQ17
          nxt_alm_rx[6] = odp_gt(lo_a, nxt_meas[q], sg); // see RQ17
          nxt_wrn_rx[7] = odp_gt(nxt_meas[q], hi_w, sg); // see RQ19
          nxt_wrn_rx[6] = odp_gt(lo_w, nxt_meas[q], sg); // see RQ19
        end else begin
          bh = 7 - 2 * q;
          nxt_alm[bh] = odp_gt(nxt_meas[q], hi_a, sg); // see RQ16
          nxt_alm[bh-1] = odp_gt(lo_a, nxt_meas[q], sg); // see RQ16
          nxt_wrn[bh] = odp_gt(nxt_meas[q], hi_w, sg); // see RQ18
          nxt_wrn[bh-1] = odp_gt(lo_w, nxt_meas[q], sg); // see RQ18
        end
      end
    end
  end

  // Keeps byte 95 equal to the sum of bytes 0 to 94, defaults included.
  always_comb begin
    nxt_cksum = `ODP_ZERO_BYTE;
    for (int i = 0; i < `ODP_THR_BYTES; i++) begin
      nxt_cksum = nxt_cksum + thr_ff[i]; // see RQ8
    end
    for (int i = `ODP_CAL_FIRST; i <= `ODP_CAL_LAST; i++) begin
      nxt_cksum = nxt_cksum + `ODP_CAL_DEFAULT; // see RQ8
    end
  end

  // Read data multiplexer; unmapped and reserved bytes read zero.
  always_comb begin
    logic [7:0] mo;
    mo = byte_addr - `ODP_MEAS_FIRST;
    nxt_rd_valid = rd_en && dev_hit; // see RQ1
    nxt_rd_data = `ODP_ZERO_BYTE;
    if (byte_addr <= `ODP_THR_LAST) begin
      nxt_rd_data = thr_ff[byte_addr[5:0]]; // see RQ21
    end else if (byte_addr >= `ODP_CAL_FIRST && byte_addr <= `ODP_CAL_LAST) begin
      nxt_rd_data = `ODP_CAL_DEFAULT; // see RQ7
    end else if (byte_addr == `ODP_CKSUM_ADDR) begin
      nxt_rd_data = cksum_ff; // see RQ8
    end else if (byte_addr >= `ODP_MEAS_FIRST && byte_addr <= `ODP_MEAS_LAST) begin
      nxt_rd_data = mo[0] ? meas_ff[mo[3:1]][7:0] : meas_ff[mo[3:1]][15:8]; // see RQ20
    end else if (byte_addr == `ODP_STAT_ADDR) begin
      nxt_rd_data = status_byte;
    end else if (byte_addr == `ODP_ALM_ADDR) begin
      nxt_rd_data = alm_ff; // see RQ16
    end else if (byte_addr == `ODP_ALM_RX_ADDR) begin
      nxt_rd_data = alm_rx_ff; // see RQ17
    end else if (byte_addr == `ODP_WRN_ADDR) begin
      nxt_rd_data = wrn_ff; // see RQ18
    end else if (byte_addr == `ODP_WRN_RX_ADDR) begin
      nxt_rd_data = wrn_rx_ff; // see RQ19
    end
  end

  // Transmitter disable and the counter that times a pending soft command.
  always_comb begin
    nxt_tx_disable = soft_off_ff | off_sync_ff; // see RQ11
    nxt_resp_cnt = `ODP_RESP_CNT_W'(0);
    if (tx_disable_out_ff != nxt_tx_disable) begin
      nxt_resp_cnt = resp_cnt_ff + `ODP_RESP_CNT_W'(1); // see RQ15
    end
  end

  // Registers all state; the transmit-off pin passes two flip-flops first.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      thr_ff <= '{default: `ODP_ZERO_BYTE};
      meas_ff <= '{default: `ODP_ZERO_WORD};
      alm_ff <= `ODP_ZERO_BYTE;
      alm_rx_ff <= `ODP_ZERO_BYTE;
      wrn_ff <= `ODP_ZERO_BYTE;
      wrn_rx_ff <= `ODP_ZERO_BYTE;
      cksum_ff <= `ODP_CKSUM_RST;
      soft_off_ff <= 1'b0;
      not_ready_ff <= 1'b1;
      off_meta_ff <= 1'b0;
      off_sync_ff <= 1'b0;
      rd_data_ff <= `ODP_ZERO_BYTE;
      rd_valid_ff <= 1'b0;
      tx_disable_out_ff <= 1'b0;
      tx_fault_pin_ff <= 1'b0;
      receive_signal_lost_pin_ff <= 1'b0;
      resp_cnt_ff <= `ODP_RESP_CNT_W'(0);
    end else begin
      thr_ff <= nxt_thr;
      meas_ff <= nxt_meas;
      alm_ff <= nxt_alm;
      alm_rx_ff <= nxt_alm_rx;
      wrn_ff <= nxt_wrn;
      wrn_rx_ff <= nxt_wrn_rx;
      cksum_ff <= nxt_cksum;
      soft_off_ff <= nxt_soft_off;
      not_ready_ff <= nxt_not_ready;
      off_meta_ff <= tx_off_pin;
      off_sync_ff <= off_meta_ff;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      tx_disable_out_ff <= nxt_tx_disable;
      tx_fault_pin_ff <= tx_fault_in; // see RQ12
      receive_signal_lost_pin_ff <= receive_signal_lost_pin_in; // see RQ13
      resp_cnt_ff <= nxt_resp_cnt;
    end
  end

  default clocking odp_cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Host accesses that the properties below are built from.
  sequence s_soft_write;
    wr_en && dev_hit && byte_addr == `ODP_STAT_ADDR;
  endsequence

  sequence s_status_read;
    rd_en && dev_hit && byte_addr == `ODP_STAT_ADDR;
  endsequence

  sequence s_flag_write;
    wr_en && dev_hit && byte_addr == `ODP_ALM_ADDR && !meas_valid;
  endsequence

  // Checks on the soft transmit-off path, readiness, flags, device select and status reads.
  a_pin_or_soft: assert property (##1 // see RQ11
      tx_disable_out_ff == $past(soft_off_ff | off_sync_ff))
    else $error("Transmit disable does not follow soft bit OR pin.");
  a_soft_bit_kept: assert property (s_soft_write // see RQ10
      |=> soft_off_ff == $past(wr_data[`ODP_ST_SOFT_BIT]))
    else $error("Soft transmit-off bit did not take the written value.");
  a_soft_resp_time: assert property (resp_cnt_ff < SOFT_RESP_CYC) // see RQ15
    else $error("Soft command took too long to reach the output.");
  a_soft_to_pin: assert property (s_soft_write ##1 !off_sync_ff[*2] // see RQ15
      |=> tx_disable_out_ff == $past(soft_off_ff))
    else $error("Soft write not on transmit disable two cycles later.");
  a_ready_clear: assert property (meas_valid |=> !not_ready_ff) // see RQ14
    else $error("Not-ready bit still set after a measurement update.");
  a_ready_hold: assert property (not_ready_ff && !meas_valid |=> not_ready_ff) // see RQ14
    else $error("Not-ready bit cleared without a measurement.");
  a_flags_stable: assert property (!meas_valid // see RQ22
      |=> $stable(alm_ff) && $stable(wrn_rx_ff))
    else $error("Flag byte changed without a measurement update.");
  a_rx_reserved: assert property (alm_rx_ff[5:0] == 6'h00 && wrn_rx_ff[5:0] == 6'h00) // see RQ17
    else $error("Reserved flag bits are not zero.");
  a_other_addr: assert property (rd_en && !dev_hit |=> !rd_valid_ff) // see RQ1
    else $error("Read answered at a foreign device address.");
  a_status_read: assert property (s_status_read // see RQ23 RQ9
      |=> rd_data_ff[5:3] == 3'h0 && rd_data_ff[`ODP_ST_TXOFF_BIT] == $past(off_sync_ff))
    else $error("Status byte read back wrong.");
  a_temp_high: assert property (meas_valid // see RQ16
      && $signed(meas_temp) > $signed({thr_ff[0], thr_ff[1]})
      |=> alm_ff[7])
    else $error("Temperature high alarm not set above threshold.");

  // Every read at the page's own address is answered one cycle later.
  a_read_answered: assert property (rd_en && dev_hit |=> rd_valid_ff) // see RQ1
    else $error("Read at the page address was not answered.");

  // Fault and loss outputs follow their inputs one cycle late.
  a_fault_follow: assert property (##1 tx_fault_pin_ff == $past(tx_fault_in)) // see RQ12
    else $error("Transmit-fault output does not follow its input.");
  a_los_follow: assert property (##1 // see RQ13
      receive_signal_lost_pin_ff == $past(receive_signal_lost_pin_in))
    else $error("Loss-of-signal output does not follow its input.");

  // The live bits of a status read show the state of the cycle before.
  a_status_bits: assert property (s_status_read // see RQ12 RQ13 RQ14 RQ10
      |=> rd_data_ff[`ODP_ST_FAULT_BIT] == $past(tx_fault_pin_ff)
      && rd_data_ff[`ODP_ST_LOS_BIT] == $past(receive_signal_lost_pin_ff)
      && rd_data_ff[`ODP_ST_SOFT_BIT] == $past(soft_off_ff)
      && rd_data_ff[`ODP_ST_NRDY_BIT] == $past(not_ready_ff))
    else $error("Status byte live bits read back wrong.");

  // A host write to the alarm flag byte 112 leaves it alone.
  a_flag_write_ignored: assert property (s_flag_write |=> $stable(alm_ff)) // see RQ22
    else $error("Flag byte took a host write.");

  // Thresholds change only through factory programming.
  a_thr_locked: assert property (wr_en && !prog_en |=> thr_ff[0] == $past(thr_ff[0])) // see RQ21
    else $error("Threshold changed without programming enable.");
  a_thr_written: assert property (wr_en && dev_hit && prog_en // see RQ21
      && byte_addr == `ODP_ZERO_BYTE |=> thr_ff[0] == $past(wr_data))
    else $error("Programmed threshold byte not stored.");

  // Low-side comparisons for receive power alarm and supply warning.
  a_rx_low: assert property (meas_valid // see RQ17
      && meas_rxpwr < {thr_ff[`ODP_RX_MEAS*`ODP_THR_STRIDE+`ODP_THR_LWA],
                       thr_ff[`ODP_RX_MEAS*`ODP_THR_STRIDE+`ODP_THR_LWA+1]}
      |=> alm_rx_ff[6])
    else $error("Receive power low alarm not set below threshold.");
  a_vcc_low_warn: assert property (meas_valid // see RQ18
      && meas_vcc < {thr_ff[`ODP_THR_STRIDE+`ODP_THR_LWR], thr_ff[`ODP_THR_STRIDE+`ODP_THR_LWR+1]}
      |=> wrn_ff[4])
    else $error("Supply low warning not set below threshold.");

endmodule

// ---- odp_defs.svh ----
`ifndef ODP_DEFS_SVH
`define ODP_DEFS_SVH

// Device select: the diagnostic page answers at two-wire address A2h (7-bit form).
`define ODP_DIAG_DEV_ADDR 7'h51

// Byte offsets within the diagnostic page.
`define ODP_THR_LAST 8'h27
`define ODP_CAL_FIRST 8'h38
`define ODP_CAL_LAST 8'h5E
`define ODP_CKSUM_ADDR 8'h5F
`define ODP_MEAS_FIRST 8'h60
`define ODP_MEAS_LAST 8'h69
`define ODP_STAT_ADDR 8'h6E
`define ODP_ALM_ADDR 8'h70
`define ODP_ALM_RX_ADDR 8'h71
`define ODP_WRN_ADDR 8'h74
`define ODP_WRN_RX_ADDR 8'h75

// Bit positions of the status/control byte.
`define ODP_ST_TXOFF_BIT 7
`define ODP_ST_SOFT_BIT 6
`define ODP_ST_FAULT_BIT 2
`define ODP_ST_LOS_BIT 1
`define ODP_ST_NRDY_BIT 0

// Sizes of the stored areas.
`define ODP_THR_BYTES 40
`define ODP_N_MEAS 5
`define ODP_THR_STRIDE 8
`define ODP_THR_LWA 2
`define ODP_THR_HWR 4
`define ODP_THR_LWR 6
`define ODP_RX_MEAS 4

// Reset and default values.
`define ODP_CAL_DEFAULT 8'h00
`define ODP_CKSUM_RST 8'h00
`define ODP_ZERO_BYTE 8'h00
`define ODP_ZERO_WORD 16'h0000

// Soft command response time and clock period.
`define ODP_SOFT_RESP_MS 100
`define ODP_NS_PER_MS 1000000
`define ODP_CLK_PERIOD_NS 40
`define ODP_RESP_CNT_W 22

`endif

// ---- odp_pkg.sv ----
package odp_pkg;
  typedef logic [7:0] odp_byte_type;
  typedef logic [15:0] odp_word_type;
  typedef logic [7:0] odp_addr_type;
endpackage

// ---- odp_host_model.sv ----
`timescale 1ns/10ps
// Host controller on the management link; issues one-cycle read and write requests.
module odp_host_model (
  input wire logic core_clk,
  output logic [6:0] dev_sel_addr,
  output logic [7:0] byte_addr,
  output logic rd_en,
  output logic wr_en,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data_ff,
  input wire logic rd_valid_ff
);
  // The bus starts idle with no request.
  initial begin
    dev_sel_addr = 7'h00;
    byte_addr = 8'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
  end
  // One access; lines are inverted after the taking edge so stale values never match.
  task automatic xfer(input logic [6:0] dev, input logic [7:0] a, input logic wr,
                      input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge core_clk);
    #1;
    dev_sel_addr = dev;
    byte_addr = a;
    wr_data = d;
    rd_en = !wr;
    wr_en = wr;
    @(posedge core_clk);
    #1;
    rd_en = 1'b0;
    wr_en = 1'b0;
    dev_sel_addr = ~dev;
    byte_addr = ~a;
    wr_data = ~d;
    q = rd_data_ff;
    v = rd_valid_ff;
  endtask
endmodule

// ---- optical_module_diag_status_page_tb.sv ----
`timescale 1ns/10ps
module optical_module_diag_status_page_tb;
  logic core_clk, sys_rst, prog_en, meas_valid, tx_off_pin, tx_fault_in, receive_signal_lost_pin_in;
  logic [6:0] dev;
  logic [7:0] addr, wdat, rdat;
  logic rd_en, wr_en, rvld, tx_dis, flt, los;
  logic [15:0] mv [0:4];
  logic [7:0] exp_pg [0:127];
  int miscompares, num_checks, cyc;
  odp_host_model host_u (.core_clk(core_clk), .dev_sel_addr(dev), .byte_addr(addr),
    .rd_en(rd_en), .wr_en(wr_en), .wr_data(wdat), .rd_data_ff(rdat), .rd_valid_ff(rvld));
  odp_diag_page #(.SOFT_RESP_CYC(8)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .dev_sel_addr(dev), .byte_addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wdat),
    .prog_en(prog_en), .meas_valid(meas_valid), .meas_temp(mv[0]), .meas_vcc(mv[1]),
    .meas_bias(mv[2]), .meas_txpwr(mv[3]), .meas_rxpwr(mv[4]), .tx_off_pin(tx_off_pin),
    .tx_fault_in(tx_fault_in), .receive_signal_lost_pin_in(receive_signal_lost_pin_in), .rd_data_ff(rdat), .rd_valid_ff(rvld),
    .tx_disable_out_ff(tx_dis), .tx_fault_pin_ff(flt), .receive_signal_lost_pin_ff(los));
  // Free-running clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Cuts a hang short.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_b({7'h00, g}, {7'h00, e});
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic v;
    host_u.xfer(7'h51, a, 1'b0, 8'h00, q, v);
    chk_bit(v, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic v;
    host_u.xfer(7'h51, a, 1'b1, d, q, v);
  endtask
  // Reads the whole lower page and compares it with the expected image.
  task automatic t_page(input string nm);
    logic [7:0] q;
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 95; i++) s = s + exp_pg[i];
    exp_pg[95] = s;
    for (int i = 0; i < 128; i++) begin
      rd(i[7:0], q);
      chk_b(q, exp_pg[i]);
    end
    $display("test page %s done", nm);
  endtask
  task automatic t_devsel();
    logic [7:0] q;
    logic v;
    host_u.xfer(7'h50, 8'h6E, 1'b0, 8'h00, q, v);
    chk_bit(v, 1'b0);
    host_u.xfer(7'h50, 8'h6E, 1'b1, 8'h40, q, v);
    rd(8'h6E, q);
    chk_b(q, exp_pg[110]);
    $display("test devsel done");
  endtask
  task automatic t_thr();
    logic [15:0] th [0:3];
    th = '{16'h7000, 16'h1000, 16'h6000, 16'h2001};
    wr(8'h00, 8'h55);
    prog_en = 1'b1;
    for (int q = 0; q < 5; q++)
      for (int k = 0; k < 4; k++) begin
        {exp_pg[8 * q + 2 * k], exp_pg[8 * q + 2 * k + 1]} = th[k];
        wr(8'(8 * q + 2 * k), th[k][15:8]);
        wr(8'(8 * q + 2 * k + 1), th[k][7:0]);
      end
    prog_en = 1'b0;
    wr(8'h00, 8'hAA);
    wr(8'h5F, 8'hFF);
    wr(8'h70, 8'hFF);
    wr(8'h38, 8'hFF);
    t_page("thresholds");
  endtask
  task automatic meas(input logic [15:0] t, v, b, x, r, input logic [7:0] a0, a1, w0, w1);
    @(posedge core_clk);
    #1;
    {mv[0], mv[1], mv[2], mv[3], mv[4]} = {t, v, b, x, r};
    meas_valid = 1'b1;
    @(posedge core_clk);
    #1;
    meas_valid = 1'b0;
    for (int i = 0; i < 5; i++) {exp_pg[96 + 2 * i], exp_pg[97 + 2 * i]} = mv[i];
    {exp_pg[112], exp_pg[113], exp_pg[116], exp_pg[117]} = {a0, a1, w0, w1};
    exp_pg[110][0] = 1'b0;
  endtask
  task automatic flags();
    logic [7:0] q;
    rd(8'h70, q);
    chk_b(q, exp_pg[112]);
    rd(8'h71, q);
    chk_b(q, exp_pg[113]);
    rd(8'h74, q);
    chk_b(q, exp_pg[116]);
    rd(8'h75, q);
    chk_b(q, exp_pg[117]);
  endtask
  task automatic t_flags();
    meas(16'h7001, 16'h7001, 16'h7001, 16'h7001, 16'h7001, 8'hAA, 8'h80, 8'hAA, 8'h80);
    flags();
    meas(16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 8'h55, 8'h40, 8'h55, 8'h40);
    flags();
    meas(16'h7000, 16'h7000, 16'h7000, 16'h7000, 16'h7000, 8'h00, 8'h00, 8'hAA, 8'h80);
    flags();
    meas(16'hF000, 16'h4001, 16'h4102, 16'h4203, 16'h4304, 8'h40, 8'h00, 8'h40, 8'h00);
    flags();
    t_page("measurements");
  endtask
  task automatic t_status();
    logic [7:0] q;
    wr(8'h6E, 8'hFF);
    exp_pg[110] = 8'h40;
    rd(8'h6E, q);
    chk_b(q, exp_pg[110]);
    chk_bit(tx_dis, 1'b1);
    wr(8'h6E, 8'h00);
    tx_off_pin = 1'b1;
    tx_fault_in = 1'b1;
    receive_signal_lost_pin_in = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    rd(8'h6E, q);
    chk_b(q, 8'h86);
    chk_bit(tx_dis, 1'b1);
    chk_bit(flt & los, 1'b1);
    tx_off_pin = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk_bit(tx_dis, 1'b0);
    $display("test status done");
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    sys_rst = 1'b1;
    prog_en = 1'b0;
    meas_valid = 1'b0;
    tx_off_pin = 1'b0;
    tx_fault_in = 1'b0;
    receive_signal_lost_pin_in = 1'b0;
    foreach (mv[i]) mv[i] = 16'h0000;
    foreach (exp_pg[i]) exp_pg[i] = 8'h00;
    exp_pg[110] = 8'h01;
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    t_page("reset");
    t_devsel();
    t_thr();
    t_flags();
    t_status();
    final_report();
  end
endmodule
